// >>> design/wdt_consts.svh
// Constants for the watchdog timer: timing, register map, field positions, reset values
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// Timing
`define WDT_CLK_HZ 100000000
`define WDT_LFOSC_HZ 31000
`define WDT_BASE_TICK_US 1000
`define WDT_LF_DIV (`WDT_CLK_HZ / `WDT_LFOSC_HZ)
`define WDT_LF_PER_TICK ((`WDT_LFOSC_HZ * `WDT_BASE_TICK_US) / 1000000)
`define WDT_CNT_W 18
`define WDT_PS_MAX 5'h12

// Register byte addresses
`define WDT_ADDR_W 8
`define WDT_A_CTRL 8'h00
`define WDT_A_CFG 8'h04
`define WDT_A_STATUS 8'h08
`define WDT_A_PWR 8'h0C
`define WDT_A_IRQ_STAT 8'h10
`define WDT_A_IRQ_CLR 8'h14
`define WDT_A_IRQ_EN 8'h18
`define WDT_A_COUNT 8'h1C

// Field positions
`define WDT_F_SWEN 0
`define WDT_F_PS_LO 1
`define WDT_F_PS_HI 5
`define WDT_F_MODE_LO 0
`define WDT_F_MODE_HI 1
`define WDT_F_TO 0
`define WDT_F_PD 1
`define WDT_F_RCAUSE 0
`define WDT_IRQ_TIMEOUT 0
`define WDT_IRQ_WAKE 1

// Reset values
`define WDT_PS_RST 5'h0B
`define WDT_MODE_RST 2'h3
`define WDT_SWEN_RST 1'h0

// Mode encodings
`define WDT_MODE_OFF 2'h0
`define WDT_MODE_SW 2'h1
`define WDT_MODE_AWAKE 2'h2
`define WDT_MODE_ON 2'h3

// Bus responses
`define WDT_RESP_OKAY 2'h0
`define WDT_RESP_SLVERR 2'h2

`endif

// >>> design/wdt_pkg.sv
// Types shared by the watchdog timer modules
package wdt_pkg;

	typedef enum logic [1:0] {
		WDT_WR_IDLE = 2'h1,
		WDT_WR_RESP = 2'h2
	} wdt_wr_state_t;

endpackage

// >>> design/wdt_tick.sv
// Base tick generator: low-frequency oscillator divider and 1 ms tick
`timescale 1ns/1ps
`include "wdt_consts.svh"

module wdt_tick #(
	parameter logic [15:0] LF_DIV = 16'(`WDT_LF_DIV),
	parameter logic [7:0] LF_PER_TICK = 8'(`WDT_LF_PER_TICK)
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic clr,
	// Tick out
	output logic tick
);

	logic [15:0] div_r;
	logic [7:0] lf_r;
	logic lf_edge;
	logic tick_r;

	assign lf_edge = (div_r == LF_DIV - 16'h0001);
	assign tick = tick_r;

	always_ff @(posedge aclk) begin
		if (!aresetn || clr) begin
			div_r <= 16'h0000;
			lf_r <= 8'h00;
			tick_r <= 1'b0;
		end else begin
			div_r <= lf_edge ? 16'h0000 : div_r + 16'h0001;
			tick_r <= lf_edge && (lf_r == LF_PER_TICK - 8'h01);
			if (lf_edge) begin
				lf_r <= (lf_r == LF_PER_TICK - 8'h01) ? 8'h00 : lf_r + 8'h01;
			end
		end
	end

endmodule // wdt_tick

// >>> design/wdt_top.sv
// Watchdog timer with four modes, sleep handling and an AXI4-Lite register port
`timescale 1ns/1ps
`include "wdt_consts.svh"

// Overview of operation
// RQ1 - Counter advances on a 1 ms tick made from a 31 kHz oscillator.
// RQ2 - Two-bit mode field picks four modes; 00 disables the watchdog completely.
// RQ3 - Mode 11 runs always, also in sleep, ignoring the software enable.
// RQ4 - Mode 10 runs while awake and is disabled while sleeping.
// RQ5 - Mode 01 runs only while the software enable bit is one.
// RQ6 - In mode 01 sleep does not change whether protection is enabled.
// RQ7 - Period select sets time-out from 1 ms up to about 256 s.
// RQ8 - After reset the period select gives a two second time-out.
// RQ9 - Counter cleared by any reset and by the clear instruction.
// RQ10 - Counter cleared on entering sleep and again on leaving sleep.
// RQ11 - If enabled in sleep, counting restarts from zero after entry clear.
// RQ12 - Counter held clear while disabled or while oscillator failure is seen.
// RQ13 - In mode 10 sleep entry clears the counter as the watchdog stops.
// RQ14 - Counter held clear while the oscillator start-up timer runs.
// RQ15 - Time-out during sleep wakes the core instead of resetting it.
// RQ16 - Time-out updates time-out and power-down flags; a time-out while awake sets reset-cause flag.
// RQ17 - Changing the internal oscillator divider leaves the counter untouched.
// RQ18 - Time-out while awake and active requests a device reset.
// RQ19 - Period codes form a power-of-two ladder of the 1 ms tick.
module wdt_top #(
	parameter logic [15:0] LF_DIV = 16'(`WDT_LF_DIV),
	parameter logic [7:0] LF_PER_TICK = 8'(`WDT_LF_PER_TICK)
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [`WDT_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [`WDT_ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Core side
	input wire logic wdog_clear_instr,
	input wire logic core_sleep,
	input wire logic osc_fail,
	input wire logic osc_startup_timer,
	input wire logic [3:0] int_osc_divider_sel,
	// Requests to the core and reset logic
	output logic reset_req,
	output logic wake_req,
	output logic irq
);

	// Register state
	logic sw_wdog_enable_r;
	logic [4:0] wdog_period_sel_r;
	logic [1:0] wdog_mode_cfg_r;
	logic timeout_flag_n_r;
	logic powerdown_flag_n_r;
	logic wdog_reset_cause_flag_r;
	logic [1:0] irq_stat_r;
	logic [1:0] irq_en_r;

	// Watchdog core state
	logic [`WDT_CNT_W-1:0] cnt_r;
	logic sleep_d_r;
	logic reset_req_r;
	logic wake_req_r;

	// Bus state
	wdt_pkg::wdt_wr_state_t wr_state_r;
	logic aw_got_r;
	logic w_got_r;
	logic [`WDT_ADDR_W-1:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;

	// Period limit for a select code, codes above the top step saturate
	function automatic logic [`WDT_CNT_W-1:0] period_limit(input logic [4:0] sel);
		logic [4:0] s;
		s = (sel > `WDT_PS_MAX) ? `WDT_PS_MAX : sel;
		period_limit = (`WDT_CNT_W'(1) << s) - `WDT_CNT_W'(1); // see RQ19
	endfunction

	// Address decode shared by read and write paths
	function automatic logic addr_mapped(input logic [`WDT_ADDR_W-1:0] a);
		addr_mapped = (a == `WDT_A_CTRL) || (a == `WDT_A_CFG) || (a == `WDT_A_STATUS) ||
			(a == `WDT_A_PWR) || (a == `WDT_A_IRQ_STAT) || (a == `WDT_A_IRQ_CLR) ||
			(a == `WDT_A_IRQ_EN) || (a == `WDT_A_COUNT);
	endfunction

	// Mode decode
	wire mode_on = (wdog_mode_cfg_r == `WDT_MODE_ON); // see RQ3
	wire mode_awake = (wdog_mode_cfg_r == `WDT_MODE_AWAKE) && !core_sleep; // see RQ4
	wire mode_sw = (wdog_mode_cfg_r == `WDT_MODE_SW) && sw_wdog_enable_r; // see RQ5
	// Mode 00 never matches any term, and mode 01 ignores sleep entirely
	wire wdog_active = mode_on || mode_awake || mode_sw; // see RQ2, see RQ6

	// Sleep edges
	wire sleep_enter = core_sleep && !sleep_d_r;
	wire sleep_exit = !core_sleep && sleep_d_r;

	// The divider select is deliberately not part of the clear term
	wire wdog_clr = wdog_clear_instr // see RQ9
		|| sleep_enter || sleep_exit // see RQ10, see RQ13
		|| osc_fail || !wdog_active // see RQ12
		|| osc_startup_timer; // see RQ14, see RQ17

	// Time base
	logic base_tick;

	wdt_tick #(
		.LF_DIV(LF_DIV),
		.LF_PER_TICK(LF_PER_TICK)
	) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.clr(wdog_clr),
		.tick(base_tick)
	); // see RQ1

	wire [`WDT_CNT_W-1:0] limit = period_limit(wdog_period_sel_r); // see RQ7
	wire timeout = !wdog_clr && base_tick && (cnt_r == limit);
	wire timeout_asleep = timeout && core_sleep;
	wire timeout_awake = timeout && !core_sleep;

	// Write channel handshakes
	wire wr_idle = (wr_state_r == wdt_pkg::WDT_WR_IDLE);
	assign s_axi_awready = !aw_got_r && wr_idle;
	assign s_axi_wready = !w_got_r && wr_idle;
	wire aw_fire = s_axi_awvalid && s_axi_awready;
	wire w_fire = s_axi_wvalid && s_axi_wready;
	wire do_write = aw_got_r && w_got_r && wr_idle;
	wire wr_lane0 = do_write && w_strb_r[0];

	// Write decode
	wire wr_ctrl = wr_lane0 && (aw_addr_r == `WDT_A_CTRL);
	wire wr_cfg = wr_lane0 && (aw_addr_r == `WDT_A_CFG);
	wire wr_pwr = wr_lane0 && (aw_addr_r == `WDT_A_PWR);
	wire wr_irq_clr = wr_lane0 && (aw_addr_r == `WDT_A_IRQ_CLR);
	wire wr_irq_en = wr_lane0 && (aw_addr_r == `WDT_A_IRQ_EN);
	wire [1:0] wr_resp = addr_mapped(aw_addr_r) ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;

	// Read channel
	assign s_axi_arready = !rvalid_r;
	wire ar_fire = s_axi_arvalid && s_axi_arready;

	// Read data mux
	wire [31:0] rd_ctrl = {26'h0, wdog_period_sel_r, sw_wdog_enable_r};
	wire [31:0] rd_cfg = {30'h0, wdog_mode_cfg_r};
	wire [31:0] rd_status = {30'h0, powerdown_flag_n_r, timeout_flag_n_r};
	wire [31:0] rd_pwr = {31'h0, wdog_reset_cause_flag_r};
	wire [31:0] rd_irq_stat = {30'h0, irq_stat_r};
	wire [31:0] rd_irq_en = {30'h0, irq_en_r};
	wire [31:0] rd_count = {{(32 - `WDT_CNT_W){1'b0}}, cnt_r};
	wire [31:0] rd_mux =
		(s_axi_araddr == `WDT_A_CTRL) ? rd_ctrl :
		(s_axi_araddr == `WDT_A_CFG) ? rd_cfg :
		(s_axi_araddr == `WDT_A_STATUS) ? rd_status :
		(s_axi_araddr == `WDT_A_PWR) ? rd_pwr :
		(s_axi_araddr == `WDT_A_IRQ_STAT) ? rd_irq_stat :
		(s_axi_araddr == `WDT_A_IRQ_EN) ? rd_irq_en :
		(s_axi_araddr == `WDT_A_COUNT) ? rd_count : 32'h0000_0000;
	wire [1:0] rd_resp = addr_mapped(s_axi_araddr) ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;

	// Interrupt status next value: set wins over clear
	wire [1:0] irq_set = {wake_req_r, reset_req_r};
	wire [1:0] irq_clr_bits = wr_irq_clr ? w_data_r[1:0] : 2'h0;
	wire [1:0] irq_stat_nxt = (irq_stat_r & ~irq_clr_bits) | irq_set;

	// Outputs
	assign s_axi_bvalid = (wr_state_r == wdt_pkg::WDT_WR_RESP);
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign reset_req = reset_req_r;
	assign wake_req = wake_req_r;
	assign irq = |(irq_stat_r & irq_en_r);

	// Watchdog counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= `WDT_CNT_W'(0); // see RQ9
			sleep_d_r <= 1'b0;
		end else begin
			sleep_d_r <= core_sleep;
			if (wdog_clr || timeout) begin
				cnt_r <= `WDT_CNT_W'(0); // see RQ11
			end else if (base_tick) begin
				cnt_r <= cnt_r + `WDT_CNT_W'(1);
			end
		end
	end

	// Time-out outcomes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reset_req_r <= 1'b0;
			wake_req_r <= 1'b0;
		end else begin
			reset_req_r <= timeout_awake; // see RQ18
			wake_req_r <= timeout_asleep; // see RQ15
		end
	end

	// Core status flags, active low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timeout_flag_n_r <= 1'b1;
			powerdown_flag_n_r <= 1'b1;
		end else if (timeout) begin
			timeout_flag_n_r <= 1'b0; // see RQ16
			powerdown_flag_n_r <= !core_sleep;
		end else if (wdog_clear_instr) begin
			timeout_flag_n_r <= 1'b1;
			powerdown_flag_n_r <= 1'b1;
		end else if (sleep_enter) begin
			timeout_flag_n_r <= 1'b1;
			powerdown_flag_n_r <= 1'b0;
		end
	end

	// Reset-cause flag, write one to clear, a new time-out while awake wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdog_reset_cause_flag_r <= 1'b0;
		end else if (timeout_awake) begin
			wdog_reset_cause_flag_r <= 1'b1; // see RQ16
		end else if (wr_pwr && w_data_r[`WDT_F_RCAUSE]) begin
			wdog_reset_cause_flag_r <= 1'b0;
		end
	end

	// Software registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sw_wdog_enable_r <= `WDT_SWEN_RST;
			wdog_period_sel_r <= `WDT_PS_RST; // see RQ8
			wdog_mode_cfg_r <= `WDT_MODE_RST;
			irq_en_r <= 2'h0;
			irq_stat_r <= 2'h0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
			if (wr_ctrl) begin
				sw_wdog_enable_r <= w_data_r[`WDT_F_SWEN];
				wdog_period_sel_r <= w_data_r[`WDT_F_PS_HI:`WDT_F_PS_LO];
			end
			if (wr_cfg) begin
				wdog_mode_cfg_r <= w_data_r[`WDT_F_MODE_HI:`WDT_F_MODE_LO];
			end
			if (wr_irq_en) begin
				irq_en_r <= w_data_r[1:0];
			end
		end
	end

	// Write address and data capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= `WDT_ADDR_W'(0);
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else begin
			if (aw_fire) begin
				aw_got_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (do_write) begin
				aw_got_r <= 1'b0;
			end
			if (w_fire) begin
				w_got_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (do_write) begin
				w_got_r <= 1'b0;
			end
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_r <= wdt_pkg::WDT_WR_IDLE;
			bresp_r <= `WDT_RESP_OKAY;
		end else begin
			case (wr_state_r)
				wdt_pkg::WDT_WR_IDLE: begin
					if (do_write) begin
						wr_state_r <= wdt_pkg::WDT_WR_RESP;
						bresp_r <= wr_resp;
					end
				end
				wdt_pkg::WDT_WR_RESP: begin
					if (s_axi_bready) begin
						wr_state_r <= wdt_pkg::WDT_WR_IDLE;
					end
				end
				default: begin
					wr_state_r <= wdt_pkg::WDT_WR_IDLE;
				end
			endcase
		end
	end

	// Read response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `WDT_RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_mux;
			rresp_r <= rd_resp;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

endmodule // wdt_top

// >>> dv/wdt_sva.sv
// Port-level assertions for the watchdog top level
`timescale 1ns/1ps
module wdt_sva (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// Core side
	input wire logic wdog_clear_instr,
	input wire logic core_sleep,
	input wire logic osc_fail,
	input wire logic osc_startup_timer,
	input wire logic reset_req,
	input wire logic wake_req
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_CLR_INSTR: assert property (wdog_clear_instr |=> !reset_req && !wake_req)
		else $error("time-out despite clear instruction");
	AST_OSC_FAIL: assert property (osc_fail |=> !(reset_req || wake_req))
		else $error("time-out during oscillator failure");
	AST_OST_HOLD: assert property (osc_startup_timer [*2] |-> !reset_req && !wake_req)
		else $error("time-out while start-up timer runs");
	AST_SLEEP_EDGE: assert property ($changed(core_sleep) |=> !reset_req && !wake_req)
		else $error("time-out on sleep transition");
	AST_WAKE_ASLEEP: assert property (wake_req |-> $past(core_sleep))
		else $error("wake request while awake");
	AST_RST_AWAKE: assert property (reset_req |-> !$past(core_sleep) && !wake_req)
		else $error("reset request while asleep");
	AST_PULSE_ONE: assert property ($rose(reset_req) |=> !reset_req)
		else $error("reset request longer than one cycle");
	AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid)
		else $error("read data late");
	AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response held after handshake");
endmodule // wdt_sva

bind wdt_top wdt_sva u_sva (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .wdog_clear_instr, .core_sleep, .osc_fail, .osc_startup_timer, .reset_req, .wake_req);

// >>> dv/wdt_top_tb.sv
// Self-checking bench for the watchdog top level
`timescale 1ns/1ps
`include "wdt_consts.svh"
module wdt_top_tb;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic wdog_clear_instr, core_sleep, osc_fail, osc_startup_timer, reset_req, wake_req, irq;
	logic [3:0] int_osc_divider_sel;
	logic [33:0] exp_r[$];
	logic [1:0] exp_b[$];
	int mismatches, num_checks, n2, nx, rc;
	integer seed = 32'h6ea65b78;

	// Small divider values: one tick every four clocks
	wdt_top #(.LF_DIV(16'h2), .LF_PER_TICK(8'h2)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wdog_clear_instr, .core_sleep,
		.osc_fail, .osc_startup_timer, .int_osc_divider_sel, .reset_req, .wake_req, .irq);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Divider setting churns all run long
	always @(posedge aclk) int_osc_divider_sel <= 4'($random(seed));

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Result watcher: pops the oldest expectation per response
	always @(posedge aclk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
		if (s_axi_bvalid === 1'b1 && s_axi_bready) chk(34'(s_axi_bresp), 34'(exp_b.pop_front()));
		if (reset_req === 1'b1 || wake_req === 1'b1) rc++;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `WDT_RESP_OKAY);
		exp_b.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `WDT_RESP_OKAY);
		exp_r.push_back({r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic pulse_clr();
		wdog_clear_instr <= 1'b1;
		@(posedge aclk);
		wdog_clear_instr <= 1'b0;
	endtask

	// Cycles from a clear to the next time-out pulse
	task automatic wait_pulse(output int n);
		n = 0;
		while (reset_req !== 1'b1 && wake_req !== 1'b1 && n < 3000) begin
			@(posedge aclk);
			n++;
		end
	endtask

	task automatic quiet();
		int b;
		@(posedge aclk);
		b = rc;
		repeat (100) @(posedge aclk);
		chk(rc, b);
	endtask

	task automatic chk_irq(input logic e);
		chk(34'(irq), 34'(e));
	endtask

	task automatic complete_run();
		if (mismatches == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = '0;
		{wdog_clear_instr, core_sleep, osc_startup_timer} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		osc_fail = 1'b1;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`WDT_A_CTRL, 32'h16);
		rd(`WDT_A_CFG, 32'h3);
		rd(`WDT_A_STATUS, 32'h3);
		rd(`WDT_A_PWR, 32'h0);
		rd(`WDT_A_IRQ_STAT, 32'h0);
		rd(`WDT_A_COUNT, 32'h0);
		rd(8'h20, 32'h0, `WDT_RESP_SLVERR);
		wr(8'h20, 32'hFF, `WDT_RESP_SLVERR);
		wr(`WDT_A_STATUS, $random(seed));
		rd(`WDT_A_STATUS, 32'h3);
		wr(`WDT_A_CTRL, 32'h04);
		quiet();
		osc_fail <= 1'b0;
		osc_startup_timer <= 1'b1;
		quiet();
		osc_startup_timer <= 1'b0;
		wr(`WDT_A_IRQ_EN, 32'h3);
		pulse_clr();
		wait_pulse(n2);
		chk({reset_req, wake_req}, 34'h2);
		rd(`WDT_A_PWR, 32'h1);
		rd(`WDT_A_STATUS, 32'h2);
		chk_irq(1'b1);
		rd(`WDT_A_COUNT, 32'h1);
		wr(`WDT_A_CTRL, 32'h06);
		pulse_clr();
		wait_pulse(nx);
		chk(nx - n2, 16);
		wdog_clear_instr <= 1'b1;
		quiet();
		rd(`WDT_A_STATUS, 32'h3);
		wdog_clear_instr <= 1'b0;
		wr(`WDT_A_CTRL, 32'h05);
		wr(`WDT_A_CFG, 32'h0);
		quiet();
		wr(`WDT_A_PWR, 32'h1);
		rd(`WDT_A_PWR, 32'h0);
		wr(`WDT_A_IRQ_CLR, 32'h3);
		rd(`WDT_A_IRQ_STAT, 32'h0);
		chk_irq(1'b0);
		wr(`WDT_A_CFG, 32'h1);
		wr(`WDT_A_CTRL, 32'h04);
		quiet();
		wr(`WDT_A_CTRL, 32'h05);
		core_sleep <= 1'b1;
		@(posedge aclk);
		wait_pulse(nx);
		chk({reset_req, wake_req}, 34'h1);
		chk(nx, n2);
		rd(`WDT_A_STATUS, 32'h0);
		chk_irq(1'b1);
		wr(`WDT_A_CFG, 32'h2);
		quiet();
		core_sleep <= 1'b0;
		@(posedge aclk);
		wait_pulse(nx);
		chk({reset_req, wake_req}, 34'h2);
		chk(nx, n2);
		wr(`WDT_A_IRQ_EN, 32'h0);
		chk_irq(1'b0);
		wr(`WDT_A_CTRL, 32'h04);
		wr(`WDT_A_CFG, 32'h3);
		core_sleep <= 1'b1;
		@(posedge aclk);
		wait_pulse(nx);
		chk({reset_req, wake_req}, 34'h1);
		chk(nx, n2);
		aresetn <= 1'b0;
		core_sleep <= 1'b0;
		@(posedge aclk);
		aresetn <= 1'b1;
		rd(`WDT_A_CTRL, 32'h16);
		rd(`WDT_A_IRQ_EN, 32'h0);
		complete_run();
	end

	initial begin
		#100000;
		mismatches++;
		complete_run();
	end
endmodule // wdt_top_tb
